/* hdl/tsc_conversion_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module tsc_conversion_ctrl #(
   parameter int unsigned CONV_CYCLES = tsc_pkg::CONV_NORMAL_CYC,
   parameter int unsigned FAST_CYCLES = tsc_pkg::CONV_FAST_CYC,
   parameter int unsigned SPS_CONV_CYCLES = tsc_pkg::CONV_SPS_CYC,
   parameter int unsigned SPS_IDLE_CYCLES = tsc_pkg::IDLE_SPS_CYC
) (
   // system clock and reset
   input wire logic mclk,
   input wire logic reset,
   // serial port
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout,
   output logic dout_oe,
   // converter
   input wire logic [15:0] adc_result,
   output logic converting,
   // open-drain alarm pins
   output logic critical_alarm_out,
   output logic critical_alarm_oe,
   output logic limit_alarm_out,
   output logic limit_alarm_oe
);
   localparam int TW = tsc_pkg::TIMER_W;
   localparam logic [TW-1:0] CONV_LOAD = TW'(CONV_CYCLES - 1);
   localparam logic [TW-1:0] FAST_LOAD = TW'(FAST_CYCLES - 1);
   localparam logic [TW-1:0] SPS_LOAD = TW'(SPS_CONV_CYCLES - 1);
   localparam logic [TW-1:0] IDLE_LOAD = TW'(SPS_IDLE_CYCLES - 1);

   // ****************************************
   // serial clock domain
   // ****************************************
   typedef struct packed {
      logic [4:0] cnt;
   } tsc_frame_type;

   typedef struct packed {
      logic [7:0] cmd;
      logic [15:0] rx;
      logic wr_tgl;
      logic [2:0] wr_addr;
      logic [15:0] wr_data;
   } tsc_xfer_type;

   typedef struct packed {
      tsc_pkg::tsc_state_type state;
      logic [TW-1:0] timer;
      logic [7:0] cfg;
      logic [15:0] temp;
      logic [15:0] crit;
      logic [15:0] high;
      logic [15:0] low;
      logic [7:0] sh_cfg;
      logic [15:0] sh_temp;
      logic [15:0] sh_crit;
      logic [15:0] sh_high;
      logic [15:0] sh_low;
      logic wr_seen;
      logic cs_last;
      logic link_rst;
      logic dout_oe;
      logic converting;
      logic crit_out;
      logic crit_oe;
      logic limit_out;
      logic limit_oe;
   } tsc_main_type;

   tsc_frame_type fr, next_fr;
   tsc_xfer_type xf, next_xf;
   tsc_main_type m, next_m;
   logic dout_q, next_dout;
   logic [15:0] rd_word;
   logic cs_s, tgl_s;
   logic wr_evt, frame_end, timer_zero, conv_done, fast_done;
   logic [15:0] res, store_val;
   logic crit_v, high_v, low_v;
   tsc_pkg::tsc_mode_type mode, wr_mode;
   tsc_alarm_if crit_q ();
   tsc_alarm_if limit_q ();

   // bit counter; chip select high holds it clear
   always_comb begin
      next_fr = fr;
      if (fr.cnt != tsc_pkg::FRAME_DONE) next_fr.cnt = 5'(fr.cnt + 5'h01);
   end

   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         fr <= '0; // [R3]
      end else begin
         fr <= next_fr;
      end
   end

   // command then data, msb first; a write posts a toggle
   always_comb begin
      next_xf = xf;
      if (fr.cnt < tsc_pkg::FRAME_CMD_END) begin
         next_xf.cmd = {xf.cmd[6:0], din}; // [R2]
      end else if (fr.cnt < tsc_pkg::FRAME_DONE) begin
         next_xf.rx = {xf.rx[14:0], din}; // [R2]
      end
      if (fr.cnt == tsc_pkg::FRAME_LAST && !xf.cmd[tsc_pkg::CMD_READ]) begin
         next_xf.wr_tgl = ~xf.wr_tgl;
         next_xf.wr_addr = xf.cmd[2:0];
         next_xf.wr_data = {xf.rx[14:0], din};
      end
   end

   // toggle must survive frame end, so it is cleared only by system reset
   always_ff @(posedge sclk or posedge m.link_rst) begin
      if (m.link_rst) begin
         xf <= '0;
      end else begin
         xf <= next_xf;
      end
   end

   // read data comes from shadows frozen while the frame runs
   always_comb begin
      case (xf.cmd[2:0])
         tsc_pkg::ADDR_CONFIGURATION: rd_word = {8'h00, m.sh_cfg};
         tsc_pkg::ADDR_TEMPERATURE: rd_word = m.sh_temp; // [R8]
         tsc_pkg::ADDR_CRITICAL: rd_word = m.sh_crit;
         tsc_pkg::ADDR_HIGH: rd_word = m.sh_high;
         tsc_pkg::ADDR_LOW: rd_word = m.sh_low;
         default: rd_word = 16'h0000;
      endcase
   end

   always_comb begin
      next_dout = 1'b0;
      if (xf.cmd[tsc_pkg::CMD_READ] && fr.cnt >= tsc_pkg::FRAME_CMD_END
          && fr.cnt < tsc_pkg::FRAME_DONE) begin
         next_dout = rd_word[4'(tsc_pkg::FRAME_LAST - fr.cnt)];
      end
   end

   // output bit moves on the falling edge for rising-edge sampling
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         dout_q <= 1'b0;
      end else begin
         dout_q <= next_dout; // [R1]
      end
   end

   // ****************************************
   // crossings into the system clock
   // ****************************************
   tsc_sync #(.WIDTH(2), .RESET_VAL(2'b10)) u_sync (
      .mclk(mclk),
      .reset(reset),
      .d({cs_n, xf.wr_tgl}),
      .q({cs_s, tgl_s})
   );

   assign wr_evt = tgl_s != m.wr_seen;
   assign frame_end = cs_s && !m.cs_last;

   // ****************************************
   // conversion sequencer and limits
   // ****************************************
   assign mode = tsc_pkg::tsc_mode_type'(m.cfg[6:5]);
   assign wr_mode = tsc_pkg::tsc_mode_type'(xf.wr_data[6:5]);
   assign timer_zero = m.timer == '0;
   assign conv_done = (m.state == tsc_pkg::ST_CONV) && timer_zero;
   assign fast_done = (m.state == tsc_pkg::ST_FAST) && timer_zero;

   // 13-bit results drop the three low bits and carry flags there
   assign res = m.cfg[tsc_pkg::CFG_RES16] ? adc_result : {adc_result[15:3], 3'b000}; // [R25]
   assign crit_v = $signed(res) > $signed(m.crit); // [R14]
   assign high_v = $signed(res) > $signed(m.high); // [R13]
   assign low_v = $signed(res) < $signed(m.low); // [R13]
   assign store_val = m.cfg[tsc_pkg::CFG_RES16] ? res : {res[15:3], crit_v, high_v, low_v};

   // one evaluation per finished conversion other than the fast one
   assign crit_q.eval = conv_done; // [R27]
   assign crit_q.violate = crit_v; // [R14]
   assign crit_q.force_on = fast_done && ($signed(res) > $signed(tsc_pkg::FAST_CRIT_LEVEL)); // [R10]
   assign crit_q.clear = frame_end;
   assign crit_q.intr_mode = m.cfg[tsc_pkg::CFG_INTR_MODE]; // [R15]
   assign crit_q.need = m.cfg[1:0]; // [R16]
   assign limit_q.eval = conv_done; // [R27]
   assign limit_q.violate = high_v || low_v; // [R13]
   assign limit_q.force_on = fast_done && ($signed(res) > $signed(tsc_pkg::FAST_LIMIT_LEVEL)); // [R11]
   assign limit_q.clear = frame_end;
   assign limit_q.intr_mode = m.cfg[tsc_pkg::CFG_INTR_MODE]; // [R15]
   assign limit_q.need = m.cfg[1:0]; // [R16]

   tsc_fault_queue u_crit_queue (
      .mclk(mclk),
      .reset(reset),
      .q(crit_q)
   );

   tsc_fault_queue u_limit_queue (
      .mclk(mclk),
      .reset(reset),
      .q(limit_q)
   );

   // all timing counts on mclk; the serial clock never steps it
   always_comb begin
      next_m = m;
      next_m.link_rst = 1'b0;
      next_m.cs_last = cs_s;
      next_m.wr_seen = tgl_s;
      next_m.dout_oe = !cs_s; // [R3]
      // shadows only move between frames
      if (cs_s) begin
         next_m.sh_cfg = m.cfg;
         next_m.sh_temp = m.temp;
         next_m.sh_crit = m.crit;
         next_m.sh_high = m.high;
         next_m.sh_low = m.low;
      end
      if (!timer_zero) next_m.timer = TW'(m.timer - 1'b1); // [R12]
      case (m.state)
         tsc_pkg::ST_FAST, tsc_pkg::ST_CONV: begin
            if (timer_zero) begin
               next_m.temp = store_val; // [R8]
               if (mode == tsc_pkg::MODE_NORMAL) begin
                  next_m.state = tsc_pkg::ST_CONV; // [R7]
                  next_m.timer = CONV_LOAD; // [R6]
               end else if (mode == tsc_pkg::MODE_SPS && m.state == tsc_pkg::ST_CONV) begin
                  next_m.state = tsc_pkg::ST_IDLE; // [R21]
                  next_m.timer = IDLE_LOAD;
               end else if (mode == tsc_pkg::MODE_SPS) begin
                  next_m.state = tsc_pkg::ST_CONV;
                  next_m.timer = SPS_LOAD;
               end else begin
                  next_m.state = tsc_pkg::ST_SHUT; // [R17]
               end
            end
         end
         tsc_pkg::ST_IDLE: begin
            if (timer_zero) begin
               next_m.state = tsc_pkg::ST_CONV; // [R21]
               next_m.timer = SPS_LOAD;
            end
         end
         tsc_pkg::ST_SHUT: begin
            next_m.timer = '0; // [R23]
         end
         default: begin
            next_m.state = tsc_pkg::ST_SHUT;
         end
      endcase
      // register writes; a mode write may start or stop conversions
      if (wr_evt) begin
         case (xf.wr_addr)
            tsc_pkg::ADDR_CONFIGURATION: begin
               next_m.cfg = xf.wr_data[7:0]; // [R16]
               case (wr_mode)
                  tsc_pkg::MODE_ONESHOT: begin
                     next_m.state = tsc_pkg::ST_CONV; // [R18] [R20]
                     next_m.timer = CONV_LOAD;
                  end
                  tsc_pkg::MODE_SHUTDOWN: begin
                     next_m.state = tsc_pkg::ST_SHUT; // [R23]
                     next_m.timer = '0;
                  end
                  tsc_pkg::MODE_NORMAL: begin
                     if (m.state == tsc_pkg::ST_SHUT || m.state == tsc_pkg::ST_IDLE) begin
                        next_m.state = tsc_pkg::ST_CONV; // [R24]
                        next_m.timer = CONV_LOAD;
                     end
                  end
                  tsc_pkg::MODE_SPS: begin
                     if (m.state == tsc_pkg::ST_SHUT) begin
                        next_m.state = tsc_pkg::ST_CONV; // [R22]
                        next_m.timer = SPS_LOAD;
                     end
                  end
                  default: begin
                  end
               endcase
            end
            tsc_pkg::ADDR_CRITICAL: next_m.crit = xf.wr_data;
            tsc_pkg::ADDR_HIGH: next_m.high = xf.wr_data;
            tsc_pkg::ADDR_LOW: next_m.low = xf.wr_data;
            default: begin
            end
         endcase
      end
      next_m.converting = (next_m.state == tsc_pkg::ST_CONV)
         || (next_m.state == tsc_pkg::ST_FAST);
      // open drain: pull low unless the wanted level is high
      next_m.crit_out = 1'b0;
      next_m.crit_oe = crit_q.alarm != m.cfg[tsc_pkg::CFG_CRIT_POL]; // [R5] [R15]
      next_m.limit_out = 1'b0;
      next_m.limit_oe = limit_q.alarm != m.cfg[tsc_pkg::CFG_LIMIT_POL]; // [R4] [R15]
      if (reset) begin
         next_m = '0;
         next_m.state = tsc_pkg::ST_FAST; // [R9]
         next_m.timer = FAST_LOAD;
         next_m.cfg = tsc_pkg::CFG_RESET; // [R4] [R5] [R25]
         next_m.crit = tsc_pkg::CRIT_RESET;
         next_m.high = tsc_pkg::HIGH_RESET;
         next_m.low = tsc_pkg::LOW_RESET;
         next_m.cs_last = 1'b1;
         next_m.link_rst = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      m <= next_m;
   end

   assign dout = dout_q;
   assign dout_oe = m.dout_oe;
   assign converting = m.converting;
   assign critical_alarm_out = m.crit_out;
   assign critical_alarm_oe = m.crit_oe;
   assign limit_alarm_out = m.limit_out;
   assign limit_alarm_oe = m.limit_oe;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_port_enable: assert property ($fell(cs_s) |=> dout_oe ##1 1'b1) // [R3]
      else $error("data out not enabled after select");
   a_normal_restart: assert property ( // [R7]
      (conv_done && mode == tsc_pkg::MODE_NORMAL && !wr_evt)
      |=> (m.state == tsc_pkg::ST_CONV) && (m.timer == CONV_LOAD))
      else $error("normal conversion did not restart");
   a_result_store: assert property (conv_done |=> m.temp == $past(store_val)) // [R8]
      else $error("result not stored");
   a_fast_first: assert property ( // [R9]
      $fell(reset) |-> (m.state == tsc_pkg::ST_FAST) && (m.timer == FAST_LOAD))
      else $error("no fast conversion after reset");
   a_fast_crit: assert property ( // [R10]
      (crit_q.force_on && !m.cfg[tsc_pkg::CFG_CRIT_POL] && !wr_evt) |-> ##2 critical_alarm_oe)
      else $error("critical pin not low after hot fast result");
   a_fast_limit: assert property ( // [R11]
      (limit_q.force_on && !m.cfg[tsc_pkg::CFG_LIMIT_POL] && !wr_evt) |-> ##2 limit_alarm_oe)
      else $error("limit pin not low after warm fast result");
   a_oneshot_stop: assert property ( // [R17]
      (conv_done && mode == tsc_pkg::MODE_ONESHOT && !wr_evt) |=> m.state == tsc_pkg::ST_SHUT)
      else $error("one-shot did not shut down");
   a_sps_idle: assert property ( // [R21]
      (conv_done && mode == tsc_pkg::MODE_SPS && !wr_evt)
      |=> (m.state == tsc_pkg::ST_IDLE) && (m.timer == IDLE_LOAD))
      else $error("one-per-second idle not entered");
   a_shut_hold: assert property ( // [R23]
      (m.state == tsc_pkg::ST_SHUT && !wr_evt) |=> (m.state == tsc_pkg::ST_SHUT) && $stable(m.temp))
      else $error("shutdown lost its result");
   a_pin_polarity: assert property ( // [R15]
      !$rose(reset) |=> critical_alarm_oe == ($past(crit_q.alarm) != $past(m.cfg[2])))
      else $error("critical pin polarity wrong");

   c_normal_done: cover property (conv_done && mode == tsc_pkg::MODE_NORMAL);
   c_oneshot_done: cover property (conv_done && mode == tsc_pkg::MODE_ONESHOT);
   c_sps_wake: cover property (m.state == tsc_pkg::ST_IDLE && timer_zero);
   c_reg_write: cover property (wr_evt && xf.wr_addr == tsc_pkg::ADDR_CONFIGURATION);
endmodule
`default_nettype wire

/* hdl/tsc_pkg.sv */
// Behaviour
// R1: serial output bits change on the falling serial clock edge.
// R2: serial input bits are captured on the rising serial clock edge.
// R3: the port acts only while chip select is low.
// R4: limit alarm resets active low, open drain, comparator mode.
// R5: critical alarm resets open drain, active low.
// R6: a normal conversion lasts 240 ms.
// R7: normal mode starts each conversion right after the last.
// R8: each result is stored; reads give the latest result.
// R9: the first conversion after power-up is a 6 ms fast one.
// R10: fast result above 147 C asserts the critical alarm.
// R11: fast result above 64 C asserts the limit alarm.
// R12: conversion timing runs on the internal clock, not the serial clock.
// R13: result outside high or low limit raises the limit alarm.
// R14: result above the critical limit raises the critical alarm.
// R15: configuration sets alarm polarity and comparator or interrupt mode.
// R16: configuration sets resolution, power-down and fault count.
// R17: one-shot does a single conversion then shuts down.
// R18: mode field bits 6:5 of configuration at 0x01 equal 01 selects one-shot.
// R19: host waits 240 ms after a one-shot start before reading.
// R20: every write of 01 to the mode field starts one conversion.
// R21: one-per-second mode repeats 60 ms convert and 940 ms idle.
// R22: mode field 10 selects one-per-second mode.
// R23: mode field 11 shuts down and keeps the last result.
// R24: mode field 00 is continuous; leaving shutdown starts a conversion.
// R25: bit 7 set gives 16-bit results; reset gives 13-bit.
// R26: alarms need the set number of consecutive faults; a pass clears.
// R27: limits are checked once per finished conversion with its result.
`default_nettype none
package tsc_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned CONV_NORMAL_MS = 240;
   localparam int unsigned CONV_FAST_MS = 6;
   localparam int unsigned CONV_SPS_MS = 60;
   localparam int unsigned IDLE_SPS_MS = 940;
   localparam int unsigned CONV_NORMAL_CYC = CONV_NORMAL_MS * CYC_PER_MS;
   localparam int unsigned CONV_FAST_CYC = CONV_FAST_MS * CYC_PER_MS;
   localparam int unsigned CONV_SPS_CYC = CONV_SPS_MS * CYC_PER_MS;
   localparam int unsigned IDLE_SPS_CYC = IDLE_SPS_MS * CYC_PER_MS;
   localparam int TIMER_W = 28;

   // ****************************************
   // serial frame and register map
   // ****************************************
   localparam logic [4:0] FRAME_CMD_END = 5'h08;
   localparam logic [4:0] FRAME_LAST = 5'h17;
   localparam logic [4:0] FRAME_DONE = 5'h18;
   localparam int CMD_READ = 7;
   localparam logic [2:0] ADDR_CONFIGURATION = 3'h1;
   localparam logic [2:0] ADDR_TEMPERATURE = 3'h2;
   localparam logic [2:0] ADDR_CRITICAL = 3'h3;
   localparam logic [2:0] ADDR_HIGH = 3'h4;
   localparam logic [2:0] ADDR_LOW = 3'h5;

   // ****************************************
   // configuration fields and reset values
   // ****************************************
   localparam int CFG_FAULT_LSB = 0;
   localparam int CFG_CRIT_POL = 2;
   localparam int CFG_LIMIT_POL = 3;
   localparam int CFG_INTR_MODE = 4;
   localparam int CFG_MODE_LSB = 5;
   localparam int CFG_RES16 = 7;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [15:0] CRIT_RESET = 16'h4980;
   localparam logic [15:0] HIGH_RESET = 16'h2000;
   localparam logic [15:0] LOW_RESET = 16'h0500;
   // fast conversion trip points, 1/128 degree per lsb
   localparam logic [15:0] FAST_CRIT_LEVEL = 16'h4980;
   localparam logic [15:0] FAST_LIMIT_LEVEL = 16'h2000;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_ONESHOT = 2'b01,
      MODE_SPS = 2'b10,
      MODE_SHUTDOWN = 2'b11
   } tsc_mode_type;

   typedef enum logic [3:0] {
      ST_FAST = 4'b0001,
      ST_CONV = 4'b0010,
      ST_IDLE = 4'b0100,
      ST_SHUT = 4'b1000
   } tsc_state_type;

endpackage
`default_nettype wire

/* hdl/tsc_alarm_if.sv */
`timescale 1ns/100ps
`default_nettype none
// one fault queue: evaluation strobe in, alarm level out
interface tsc_alarm_if;
   logic eval;
   logic violate;
   logic force_on;
   logic clear;
   logic intr_mode;
   logic [1:0] need;
   logic alarm;
   modport ctrl (output eval, violate, force_on, clear, intr_mode, need, input alarm);
   modport queue (input eval, violate, force_on, clear, intr_mode, need, output alarm);
endinterface
`default_nettype wire

/* hdl/tsc_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module tsc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] safe;
   } tsc_sync_type;
   tsc_sync_type s, next_s;

   // the first stage feeds only the second
   always_comb begin
      next_s.meta = d;
      next_s.safe = s.meta;
      if (reset) begin
         next_s.meta = RESET_VAL;
         next_s.safe = RESET_VAL;
      end
   end

   always_ff @(posedge mclk) begin
      s <= next_s;
   end

   assign q = s.safe;
endmodule
`default_nettype wire

/* hdl/tsc_fault_queue.sv */
`timescale 1ns/100ps
`default_nettype none
module tsc_fault_queue (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // queue port
   tsc_alarm_if.queue q
);
   typedef struct packed {
      logic [2:0] cnt;
      logic alarm;
   } tsc_fq_type;
   tsc_fq_type s, next_s;
   logic [2:0] need_cnt;
   logic reach;

   assign need_cnt = {1'b0, q.need} + 3'h1;
   assign reach = q.eval && q.violate && (3'(s.cnt + 3'h1) >= need_cnt);

   // clear first so a set in the same cycle wins
   always_comb begin
      next_s = s;
      if (q.clear && q.intr_mode) next_s.alarm = 1'b0;
      if (q.eval) begin
         if (q.violate) begin
            if (s.cnt < need_cnt) next_s.cnt = 3'(s.cnt + 3'h1); // [R26]
         end else begin
            next_s.cnt = 3'h0; // [R26]
            if (!q.intr_mode) next_s.alarm = 1'b0;
         end
      end
      if (reach || q.force_on) next_s.alarm = 1'b1; // [R26]
      if (reset) next_s = '0;
   end

   always_ff @(posedge mclk) begin
      s <= next_s;
   end

   assign q.alarm = s.alarm;

   a_fq_reach_set: assert property (@(posedge mclk) disable iff (reset) // [R26]
      reach |=> s.alarm)
      else $error("alarm not set after enough faults");
   a_fq_pass_clear: assert property (@(posedge mclk) disable iff (reset) // [R26]
      (q.eval && !q.violate) |=> (s.cnt == 3'h0))
      else $error("fault count not cleared by a passing result");
endmodule
`default_nettype wire

/* sim/tsc_spi_host.sv */
`timescale 1ns/100ps
`default_nettype none
module tsc_spi_host (
   // serial pins
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout,
   input wire logic dout_oe
);
   // clock idles high and stands still between frames
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b0;
   end
   // 24-bit frame; undriven dout reads as the inverse
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
      logic [23:0] sh;
      sh = {cmd, wd};
      rd = 16'h0000;
      #3.3 cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         #7.5 sclk = 1'b0;
         din = sh[i];
         #7.5 sclk = 1'b1;
         if (i < 16) rd = {rd[14:0], dout_oe ? dout : ~dout};
      end
      #7.5 cs_n = 1'b1;
      din = ~din;
      #30; // cs_n high long enough to refresh read shadows
   endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] adc_result = 16'h7000;
   int n_mismatch = 0;
   int checks_done = 0;
   wire logic sclk, cs_n, din, dout, dout_oe, converting;
   wire logic critical_alarm_out, critical_alarm_oe, limit_alarm_out, limit_alarm_oe;
   // ****************************************
   // clock, parts
   // ****************************************
   always #2.5 mclk = ~mclk;
   tsc_conversion_ctrl #(.CONV_CYCLES(200), .FAST_CYCLES(50), .SPS_CONV_CYCLES(60),
      .SPS_IDLE_CYCLES(300)) u_tsc_conversion_ctrl (.mclk(mclk), .reset(reset), .sclk(sclk),
      .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe), .adc_result(adc_result),
      .converting(converting), .critical_alarm_out(critical_alarm_out),
      .critical_alarm_oe(critical_alarm_oe), .limit_alarm_out(limit_alarm_out),
      .limit_alarm_oe(limit_alarm_oe));
   tsc_spi_host u_tsc_spi_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
      .dout_oe(dout_oe));
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic end_sim;
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      logic [15:0] r;
      u_tsc_spi_host.xfer({5'h00, a}, d, r);
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] r);
      u_tsc_spi_host.xfer({5'h10, a}, 16'h0000, r);
   endtask
   // cycles until converting leaves the given level, bounded
   task automatic span(input logic lvl, output int n);
      n = 0;
      while (converting === lvl && n < 500) begin
         @(posedge mclk);
         #1 n++;
      end
   endtask
   // expected pin pull-downs {critical, limit} in comparator mode
   function automatic logic [1:0] pins(input logic [15:0] t, lo, hi, cr, input logic [7:0] c);
      pins[1] = ($signed(t) > $signed(cr)) != c[2];
      pins[0] = (($signed(t) > $signed(hi)) || ($signed(t) < $signed(lo))) != c[3];
   endfunction
   initial begin
      #300000 n_mismatch++;
      end_sim();
   end
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      logic [15:0] r, lo, hi, cr, t;
      logic [7:0] cfg;
      logic [1:0] e;
      int n;
      void'($urandom(98794));
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1 chk1(converting, 1'b1);
      chk1(critical_alarm_oe, 1'b0);
      chk1(limit_alarm_oe, 1'b0);
      repeat (60) @(posedge mclk);
      #1 chk1(critical_alarm_oe, 1'b1);
      chk1(limit_alarm_oe, 1'b1);
      chk1(critical_alarm_out, 1'b0);
      rd(3'h2, r);
      chk16(r, 16'h7006);
      wr(3'h1, 16'h0060);
      repeat (10) @(posedge mclk);
      #1 chk1(converting, 1'b0);
      rd(3'h1, r);
      chk16(r, 16'h0060);
      rd(3'h2, r);
      chk16(r, 16'h7006);
      rd(3'h6, r);
      chk16(r, 16'h0000);
      // one-shot with random limits, polarity and reading; first one just over high
      for (int k = 0; k < 3; k++) begin
         lo = 16'($urandom % 8192) - 16'h1000;
         hi = lo + 16'($urandom % 4096) + 16'h0001;
         cr = hi + 16'($urandom % 4096);
         t = (k == 0) ? hi + 16'h0001 : 16'($urandom % 24576) - 16'h2000;
         cfg = 8'ha0 | 8'(($urandom % 4) << 2);
         @(posedge mclk) adc_result <= t;
         wr(3'h3, cr);
         wr(3'h4, hi);
         wr(3'h5, lo);
         wr(3'h1, {8'h00, cfg});
         repeat (230) @(posedge mclk);
         e = pins(t, lo, hi, cr, cfg);
         #1 chk1(converting, 1'b0);
         chk1(critical_alarm_oe, e[1]);
         chk1(limit_alarm_oe, e[0]);
         rd(3'h2, r);
         chk16(r, t);
      end
      wr(3'h1, 16'h0040);
      span(1'b1, n);
      span(1'b0, n);
      chk1(n >= 299 && n <= 301, 1'b1);
      span(1'b1, n);
      chk1(n >= 59 && n <= 61, 1'b1);
      // a passing value empties the queue before faults are counted
      @(posedge mclk) adc_result <= lo;
      wr(3'h1, 16'h0060);
      wr(3'h1, 16'h0092);
      n = 0;
      repeat (450) begin
         @(posedge mclk);
         #1 n += (converting !== 1'b1);
      end
      chk16(16'(n), 16'h0000);
      // three faults needed, interrupt mode: two violations leave the pin alone
      @(posedge mclk) adc_result <= hi + 16'h0001;
      repeat (380) @(posedge mclk);
      #1 chk1(limit_alarm_oe, 1'b0);
      repeat (200) @(posedge mclk);
      #1 chk1(limit_alarm_oe, 1'b1);
      chk1(limit_alarm_out, 1'b0);
      // end of any frame drops a latched alarm
      rd(3'h1, r);
      chk16(r, 16'h0092);
      chk1(limit_alarm_oe, 1'b0);
      end_sim();
   end
endmodule
`default_nettype wire
